// file: logic/fpeig_top.sv
// Numeric error glue: interrupt request and ignore-error flip-flops.
`timescale 1ns/100ps
// Overview of operation
// - Two separate flip-flops hold the interrupt request and the ignore-error state.
// - An access to port 0F0H clears the numeric error interrupt request.
// - The same access sets the ignore flip-flop so the ignore output goes low.
// - While ignore is active, waiting instructions complete without the pending error.
// - Deassertion of the error output after clear-exceptions resets the ignore flip-flop.
// - Deassertion after save-and-initialise likewise clears the ignore flip-flop.
// - Reassertion of the error output by a restore never sets the ignore flip-flop.
// - A waiting instruction with an error pending and ignore inactive enters the handler.
// - No-wait instructions complete without the handler even with an error pending.

// Design notes.
// The ignore flip-flop is state the processor cannot see or save on its own. If management
// code saves and reinitialises the floating-point unit between the handler's acknowledge and
// its next waiting instruction, the error output drops and clears the ignore flip-flop; the
// later restore raises the error again but leaves ignore cleared, so the handler re-enters
// itself. The restore strobe and the ignore_active_out view exist so that management code can
// put the flip-flop back by hand.
// Priorities: an error edge beats an acknowledge on the request, and an acknowledge beats a
// restore, which beats an error release, on the ignore flip-flop.
// Every output follows its cause by one clock, and nothing here is buffered or counted.
// Limitation: a read of the acknowledge port counts as an acknowledge, just as a write does.
module fpeig_top (
  input  wire logic                    clk_in,
  input  wire logic                    arst_n_in,
  input  wire fpeig_pkg::fpeig_io_t    io_in,
  input  wire logic                    float_error_out_n_in,
  input  wire fpeig_pkg::fpeig_instr_t instr_in,
  input  wire logic                    ign_restore_in,
  input  wire logic                    ign_restore_val_in,
  output logic                         numeric_error_irq_out,
  output logic                         ignore_numeric_error_n_out,
  output logic                         ignore_active_out,
  output fpeig_pkg::fpeig_result_t     result_out
);

  // Storage and next values of both flip-flops, the error sample and the gate.
  logic                   irq_q;
  logic                   irq_d;
  logic                   ign_q;
  logic                   ign_d;
  logic                   err_n_q;
  fpeig_pkg::fpeig_gate_t gate_q;
  fpeig_pkg::fpeig_gate_t gate_d;

  // Port decode and error edge detection on the previous sample.
  wire port_hit   = (io_in.wr_strobe | io_in.rd_strobe)
                    & (io_in.addr == fpeig_pkg::ACK_PORT_ADDR);
  wire err_active = ~float_error_out_n_in;
  wire err_rise   = ~float_error_out_n_in & err_n_q;
  wire err_fall   = float_error_out_n_in & ~err_n_q;

  // Request flip-flop: a new error edge wins over a same-cycle acknowledge,
  // so an error arriving during the handler's port access is never lost.
  assign irq_d = err_rise ? 1'h1 :
                 port_hit ? 1'h0 :
                 irq_q;

  // Ignore flip-flop: set by the port access, loaded from ign_restore_val_in by the restore strobe, cleared when the error
  // output goes inactive. A restore that reasserts the error leaves it alone,
  // which is why management code must put its state back itself.
  assign ign_d = port_hit       ? 1'h1 :
                 ign_restore_in ? ign_restore_val_in :
                 err_fall       ? 1'h0 :
                 ign_q;

  // Instruction gate: pending error blocks waiting instructions unless
  // ignore is active; no-wait instructions always complete.
  always_comb begin
    gate_d = fpeig_pkg::GATE_IDLE;
    if (instr_in.nowait_issue) begin
      gate_d = fpeig_pkg::GATE_DONE;
    end else if (instr_in.wait_issue) begin
      if (err_active && !ign_q) begin
        gate_d = fpeig_pkg::GATE_TRAP;
      end else begin
        gate_d = fpeig_pkg::GATE_DONE;
      end
    end
  end

  // Two distinct storage flip-flops plus the error sample and gate state.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_q   <= fpeig_pkg::IRQ_RESET_VAL;
      ign_q   <= fpeig_pkg::IGN_RESET_VAL;
      err_n_q <= fpeig_pkg::ERR_N_RESET_VAL;
      gate_q  <= fpeig_pkg::GATE_IDLE;
    end else begin
      irq_q   <= irq_d;
      ign_q   <= ign_d;
      err_n_q <= float_error_out_n_in;
      gate_q  <= gate_d;
    end
  end

  // Outputs; the ignore pin is active low, so a set flip-flop drives it low.
  assign numeric_error_irq_out      = irq_q;
  assign ignore_numeric_error_n_out = ~ign_q;
  assign ignore_active_out          = ign_q;
  assign result_out = '{done: (gate_q == fpeig_pkg::GATE_DONE),
                        trap: (gate_q == fpeig_pkg::GATE_TRAP)};

  // Checks on the guarded behaviour.

  a_irq_sets_on_error: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (float_error_out_n_in && $past(float_error_out_n_in) == 1'h1) ##1
      !float_error_out_n_in |=> numeric_error_irq_out)
    else $error("Request not set after error assertion.");

  a_port_clears_irq: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (port_hit && !(!float_error_out_n_in && err_n_q)) |=> !numeric_error_irq_out)
    else $error("Request not cleared by port access.");

  a_port_sets_ignore: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    port_hit |=> (ignore_numeric_error_n_out == 1'h0) && ignore_active_out)
    else $error("Ignore output not driven low after port access.");

  a_deassert_clears_ign: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (!float_error_out_n_in ##1 float_error_out_n_in && !port_hit && !ign_restore_in)
      |=> ignore_numeric_error_n_out)
    else $error("Ignore not reset when error output deasserted.");

  a_restore_no_set: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (!ignore_active_out && !port_hit && !ign_restore_in) |=> !ignore_active_out)
    else $error("Ignore set without a port access.");

  a_ign_holds_no_fall: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (ignore_active_out && !float_error_out_n_in && !ign_restore_in
      ##1 !float_error_out_n_in)
      |-> ignore_active_out)
    else $error("Ignore lost while error output stayed asserted.");

  a_wait_traps: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (instr_in.wait_issue && !instr_in.nowait_issue && !float_error_out_n_in
      && !ignore_active_out) |=> result_out.trap && !result_out.done)
    else $error("Waiting instruction did not enter the handler.");

  a_ignore_completes: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (instr_in.wait_issue && ignore_active_out) |=> result_out.done && !result_out.trap)
    else $error("Waiting instruction trapped while ignore active.");

  a_nowait_completes: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    instr_in.nowait_issue |=> result_out.done && !result_out.trap)
    else $error("No-wait instruction did not complete.");

  a_trap_has_cause: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    result_out.trap |-> $past(float_error_out_n_in) == 1'h0)
    else $error("Handler entry without a pending error.");

  a_restore_loads: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (ign_restore_in && !port_hit) |=> ignore_active_out == $past(ign_restore_val_in))
    else $error("Ignore state not restored.");

  // Request flip-flop: it moves only on an error edge or an acknowledge.
  a_irq_holds_no_ack: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (numeric_error_irq_out && !port_hit)
      |=> numeric_error_irq_out)
    else $error("Request dropped without an acknowledge.");

  a_irq_no_spurious: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (!numeric_error_irq_out && !err_rise)
      |=> !numeric_error_irq_out)
    else $error("Request raised without an error edge.");

  a_other_port_ignored: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    ((io_in.wr_strobe || io_in.rd_strobe) && (io_in.addr != fpeig_pkg::ACK_PORT_ADDR)
      && numeric_error_irq_out) |=> numeric_error_irq_out)
    else $error("Request cleared by an access to another port.");

  a_port_decode_acks: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    ((io_in.wr_strobe || io_in.rd_strobe) && (io_in.addr == fpeig_pkg::ACK_PORT_ADDR)
      && float_error_out_n_in) |=> !numeric_error_irq_out && ignore_active_out)
    else $error("Acknowledge port access not decoded.");

  a_irq_restore_blind: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (ign_restore_in && !port_hit && !err_rise)
      |=> $stable(numeric_error_irq_out))
    else $error("Ignore restore disturbed the request flip-flop.");

  // Ignore flip-flop: once set it stays set until the error output is released or a restore loads a zero.
  a_ign_clear_cause: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (ignore_active_out && !ign_restore_in && !err_fall)
      |=> ignore_active_out)
    else $error("Ignore cleared without an error release.");

  // Instruction gate: a result follows an issue, and a trap needs an error with ignore off.
  a_result_has_issue: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (result_out.done || result_out.trap)
      |-> $past(instr_in.wait_issue || instr_in.nowait_issue))
    else $error("Instruction result without an issue.");

  a_wait_clean_done: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (instr_in.wait_issue && float_error_out_n_in)
      |=> result_out.done && !result_out.trap)
    else $error("Waiting instruction trapped with no error pending.");

  a_trap_no_ignore: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    result_out.trap
      |-> !$past(ignore_active_out))
    else $error("Handler entry while ignore was active.");

endmodule

// file: logic/fpeig_pkg.sv
// Package with constants and carrier types for the numeric error glue block.
package fpeig_pkg;

  // Width of the host I/O address bus.
  localparam int unsigned IO_ADDR_W = 16;

  // I/O port whose access acknowledges a numeric error.
  localparam logic [IO_ADDR_W-1:0] ACK_PORT_ADDR = 16'h00F0;

  // Values after reset: request clear, ignore output inactive (high).
  localparam logic IRQ_RESET_VAL    = 1'h0;
  localparam logic IGN_RESET_VAL    = 1'h0;
  localparam logic ERR_N_RESET_VAL  = 1'h1;
  localparam logic SAVED_RESET_VAL  = 1'h0;

  // Latency from a cause to a registered output, in clock cycles.
  localparam int unsigned OUT_LATENCY = 1;

  // One host I/O bus cycle as decoded by the bus interface.
  typedef struct packed {
    logic                 wr_strobe;
    logic                 rd_strobe;
    logic [IO_ADDR_W-1:0] addr;
  } fpeig_io_t;

  // Floating-point instruction issue from the core.
  typedef struct packed {
    logic wait_issue;
    logic nowait_issue;
  } fpeig_instr_t;

  // Result of an instruction issue.
  typedef struct packed {
    logic done;
    logic trap;
  } fpeig_result_t;

  // Instruction gate state, one-hot.
  typedef enum logic [2:0] {
    GATE_IDLE = 3'h1,
    GATE_DONE = 3'h2,
    GATE_TRAP = 3'h4
  } fpeig_gate_t;

endpackage

// file: test/fpeig_fpu_model.sv
// Behavioural model of the processor's floating-point error pin.
`timescale 1ns/100ps
module fpeig_fpu_model (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic raise_in,
  input  wire logic clear_in,
  output logic      float_error_out_n_out
);
  // Pin is low while an error is pending; a clear wins so the pin never glitches.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      float_error_out_n_out <= 1'h1;
    end else if (clear_in) begin
      float_error_out_n_out <= 1'h1;
    end else if (raise_in) begin
      float_error_out_n_out <= 1'h0;
    end
  end
endmodule

// file: test/fpeig_top_test.sv
// Self-checking bench for the numeric error glue block.
`timescale 1ns/100ps
module fpeig_top_test;
  logic clk_in = 1'h0, arst_n_in = 1'h0, raise = 1'h0, clr = 1'h0;
  logic err_n, rst_req = 1'h0, rst_val = 1'h0, irq, ign_n, act;
  fpeig_pkg::fpeig_io_t     io = '0;
  fpeig_pkg::fpeig_instr_t  ins = '0;
  fpeig_pkg::fpeig_result_t res;
  int fail_count = 0, compares = 0, cyc = 0;
  fpeig_fpu_model fpu_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .raise_in(raise),
    .clear_in(clr), .float_error_out_n_out(err_n));
  fpeig_top dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .io_in(io),
    .float_error_out_n_in(err_n), .instr_in(ins), .ign_restore_in(rst_req),
    .ign_restore_val_in(rst_val), .numeric_error_irq_out(irq),
    .ignore_numeric_error_n_out(ign_n), .ignore_active_out(act), .result_out(res));
  // Clock at 40 MHz.
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  // A hang is cut short after far more cycles than the tests need.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count = fail_count + 1;
      $display("[FAIL] run_done expected 1 seen 0");
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    compares = compares + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Pin changes pass the model and the sampler, so settle three cycles.
  task automatic pin(input logic r, input logic c);
    raise = r;
    clr = c;
    @(negedge clk_in);
    raise = 1'h0;
    clr = 1'h0;
    repeat (2) @(negedge clk_in);
  endtask
  task automatic acc(input logic w, input logic r, input logic [15:0] a);
    io = '{wr_strobe: w, rd_strobe: r, addr: a};
    @(negedge clk_in);
    io = '0;
    @(negedge clk_in);
  endtask
  task automatic issue(input logic w, input logic nw, input logic ed, input logic et);
    ins = '{wait_issue: w, nowait_issue: nw};
    @(negedge clk_in);
    ins = '0;
    chk("done", ed, res.done);
    chk("trap", et, res.trap);
    @(negedge clk_in);
  endtask
  // Error raises the request; only the acknowledge port clears it and sets ignore.
  task automatic t_ack();
    pin(1'h1, 1'h0);
    chk("irq", 1'h1, irq);
    acc(1'h1, 1'h0, 16'h00F1);
    chk("irq", 1'h1, irq);
    chk("ign_n", 1'h1, ign_n);
    acc(1'h0, 1'h1, fpeig_pkg::ACK_PORT_ADDR);
    chk("irq", 1'h0, irq);
    chk("ign_n", 1'h0, ign_n);
    issue(1'h1, 1'h0, 1'h1, 1'h0);
  endtask
  // Save clears ignore; restore re-raises the pin but leaves ignore off.
  task automatic t_swap();
    pin(1'h0, 1'h1);
    chk("ign_n", 1'h1, ign_n);
    pin(1'h1, 1'h0);
    chk("ign_n", 1'h1, ign_n);
    chk("irq", 1'h1, irq);
    issue(1'h1, 1'h0, 1'h0, 1'h1);
    issue(1'h0, 1'h1, 1'h1, 1'h0);
    acc(1'h1, 1'h0, fpeig_pkg::ACK_PORT_ADDR);
    chk("irq", 1'h0, irq);
    chk("ign_n", 1'h0, ign_n);
    issue(1'h1, 1'h0, 1'h1, 1'h0);
    pin(1'h0, 1'h1);
    chk("ign_n", 1'h1, ign_n);
  endtask
  // Management code restores the captured ignore state.
  task automatic t_cap(input logic v);
    // Management code only puts the ignore state back and does no floating-point work.
    rst_req = 1'h1;
    rst_val = v;
    @(negedge clk_in);
    rst_req = 1'h0;
    chk("act", v, act);
    chk("ign_n", ~v, ign_n);
    @(negedge clk_in);
  endtask
  // Mid-run reset with both flip-flops set clears them; a clean wait then completes.
  task automatic t_rst();
    acc(1'h1, 1'h0, fpeig_pkg::ACK_PORT_ADDR);
    pin(1'h1, 1'h0);
    chk("irq", 1'h1, irq);
    chk("act", 1'h1, act);
    arst_n_in = 1'h0;
    @(negedge clk_in);
    chk("irq", 1'h0, irq);
    chk("act", 1'h0, act);
    chk("ign_n", 1'h1, ign_n);
    chk("done", 1'h0, res.done);
    arst_n_in = 1'h1;
    @(negedge clk_in);
    issue(1'h1, 1'h0, 1'h1, 1'h0);
  endtask
  initial begin
    repeat (4) @(negedge clk_in);
    chk("irq", 1'h0, irq);
    chk("ign_n", 1'h1, ign_n);
    arst_n_in = 1'h1;
    @(negedge clk_in);
    t_ack();
    t_swap();
    t_cap(1'h1);
    t_cap(1'h0);
    t_rst();
    end_of_test();
  end
endmodule
